/* vr_startup_vid_supervisor.sv */
// Purpose: power-up sequence, VID soft transient, power-good masking, current limit latch
// Assumes: comparator inputs synchronous to clock; 20 MHz clock
// Notes:   analog loops outside; dac code drives the reference DAC
// Overview of operation
// - supply ok and enable: reset interval first
// - sample phase count, then go soft-start
// - ramp to boot code, hold 100 us
// - boot hold done drives clock-go low
// - power good after 9 ms clock-go low
// - VID used only after clock-go low
// - enable/supply loss clears soft-start and delay
// - lockout or shutdown pulls sense reference down
// - good only inside -300/+200 mV window
// - target below 300 mV: upper limit only
// - mask 130 us after VID or sleep change
// - large droop in sleep extends masking
// - new VID ignored at least 400 ns
// - every VID change in run state, except one away from OFF_CODE, restarts mask timer
// - step DAC one code at a time
// - mask 100 us after last step
// - paced 3.125 mV/us or 12.5 mV/us up
// - comparator trip enters current limit
// - output under 200 mV: clamp ramp 1.5 V
// - 9 ms continuous limit latches off
// - latch clears on power or enable cycle
// - power good open drain, pull low only
// - VID transition forces fixed PWM
`timescale 1ns/10ps
`include "vrs_defs.svh"
module vr_startup_vid_supervisor #(
	parameter int VID_W      = `VRS_VID_W,
	parameter int PGDLY_CYC  = `VRS_PGDLY_CYC,
	parameter int LIMIT_SET_PIN_CYC   = `VRS_LIMIT_SET_PIN_CYC,
	parameter int TW         = 24
) (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic             enable,
	input  wire logic             supplyOk,
	input  wire logic             phaseSelTwo,
	input  wire logic [VID_W-1:0] voltage_id_bits,
	input  wire logic             deeperSleep,
	input  wire logic             slowSleepExit,
	input  wire logic             droopOver200mV,
	input  wire logic             outAboveLow,
	input  wire logic             outAboveHigh,
	input  wire logic             outBelow200mV,
	input  wire logic             currentOver,
	input  wire logic             fastUpSlew,
	output logic [VID_W-1:0]      dacCode,
	output logic                  cpu_clock_go_n,
	output logic                  power_good_out_o,
	output logic                  power_good_out_oe_n,
	output logic                  senseRefPullDown,
	output logic                  softStartDone,
	output logic                  twoPhase,
	output logic                  forcePwm,
	output logic                  rampClamp,
	output logic                  switching,
	output logic                  latchedOff
);
	// refuse settings the counters cannot hold
	if (VID_W != 7 || PGDLY_CYC < 1 || LIMIT_SET_PIN_CYC < 1 || PGDLY_CYC >= (1 << TW)
		|| LIMIT_SET_PIN_CYC >= (1 << TW) || TW < 16) begin
		$error("vr_startup_vid_supervisor: unsupported parameters");
	end

	localparam logic [TW-1:0] RESET_CNT  = TW'(`VRS_RESET_CYC);
	localparam logic [TW-1:0] BOOT_CNT   = TW'(`VRS_BOOT_CYC);
	localparam logic [TW-1:0] PGDLY_CNT  = TW'(PGDLY_CYC);
	localparam logic [TW-1:0] LIMIT_SET_PIN_CNT   = TW'(LIMIT_SET_PIN_CYC);
	localparam logic [TW-1:0] MASK_CNT   = TW'(`VRS_MASK_CYC);
	localparam logic [TW-1:0] MASKX_CNT  = TW'(`VRS_MASK_EXT_CYC);
	localparam logic [TW-1:0] FINAL_CNT  = TW'(`VRS_FINAL_CYC);
	localparam logic [TW-1:0] SKEW_CNT   = TW'(`VRS_SKEW_CYC);
	localparam logic [TW-1:0] SLOW_CNT   = TW'(`VRS_STEP_SLOW_CYC);
	localparam logic [TW-1:0] FAST_CNT   = TW'(`VRS_STEP_FAST_CYC);
	localparam logic [VID_W-1:0] BOOT_CODE = `VRS_BOOT_CODE;
	localparam logic [VID_W-1:0] LOW_CODE  = `VRS_LOW_DAC_CODE;
	localparam logic [VID_W-1:0] OFF_CODE  = {VID_W{1'b1}};

	vrs_pkg::vrs_state_e state;
	logic                powerOn;
	logic                seqActive;
	logic                enablePrev;
	logic [VID_W-1:0]    targetCode;
	logic [VID_W-1:0]    vidSeen;
	logic                vidPending;
	logic                stepping;
	logic                sleepPrev;
	logic                maskRun;
	logic                finalRun;
	logic                ilimRun;
	logic                stepRun;
	logic                stepArmed;
	logic                goodRaw;

	vrs_timer_if #(.W(TW)) seqIf ();
	vrs_timer_if #(.W(TW)) skewIf ();
	vrs_timer_if #(.W(TW)) maskIf ();
	vrs_timer_if #(.W(TW)) finalIf ();
	vrs_timer_if #(.W(TW)) ilimIf ();
	vrs_timer_if #(.W(TW)) stepIf ();

	// every interval counted from the one clock
	vrs_timer #(.W(TW)) seqTimer   (.clock(clock), .rst_n(rst_n), .tif(seqIf));
	vrs_timer #(.W(TW)) skewTimer  (.clock(clock), .rst_n(rst_n), .tif(skewIf));
	vrs_timer #(.W(TW)) maskTimer  (.clock(clock), .rst_n(rst_n), .tif(maskIf));
	vrs_timer #(.W(TW)) finalTimer (.clock(clock), .rst_n(rst_n), .tif(finalIf));
	vrs_timer #(.W(TW)) ilimTimer  (.clock(clock), .rst_n(rst_n), .tif(ilimIf));
	vrs_timer #(.W(TW)) stepTimer  (.clock(clock), .rst_n(rst_n), .tif(stepIf));

	assign powerOn = enable && supplyOk;
	assign seqActive = state != vrs_pkg::VRS_OFF && state != vrs_pkg::VRS_LATCH;

	// sequence state
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state <= vrs_pkg::VRS_OFF;
		end else if (!supplyOk) begin
			state <= vrs_pkg::VRS_OFF;
		end else if (!enable) begin
			state <= vrs_pkg::VRS_OFF;
		end else begin
			unique case (state)
				vrs_pkg::VRS_OFF: begin
					state <= vrs_pkg::VRS_RESET;
				end
				vrs_pkg::VRS_RESET: begin
					if (seqIf.done) begin
						state <= vrs_pkg::VRS_PHASE;
					end
				end
				vrs_pkg::VRS_PHASE: begin
					state <= vrs_pkg::VRS_SOFT;
				end
				vrs_pkg::VRS_SOFT: begin
					if (dacCode == BOOT_CODE && stepIf.done) begin
						state <= vrs_pkg::VRS_BOOT;
					end
				end
				vrs_pkg::VRS_BOOT: begin
					if (seqIf.done) begin
						state <= vrs_pkg::VRS_DELAY;
					end
				end
				vrs_pkg::VRS_DELAY: begin
					if (seqIf.done) begin
						state <= vrs_pkg::VRS_RUN;
					end
				end
				vrs_pkg::VRS_RUN: begin
				end
				vrs_pkg::VRS_LATCH: begin
				end
			endcase
			if (seqActive && ilimIf.done) begin
				state <= vrs_pkg::VRS_LATCH;
			end
		end
	end

	// sequence timer loads on each entry
	always_comb begin
		seqIf.run = powerOn && (state == vrs_pkg::VRS_RESET || state == vrs_pkg::VRS_BOOT
			|| state == vrs_pkg::VRS_DELAY);
		seqIf.start = 1'b0;
		seqIf.count = RESET_CNT;
		if (state == vrs_pkg::VRS_OFF && powerOn) begin
			seqIf.start = 1'b0;
		end
		if (state == vrs_pkg::VRS_RESET && enablePrev == 1'b0) begin
			seqIf.start = 1'b1;
			seqIf.count = RESET_CNT;
		end else if (state == vrs_pkg::VRS_SOFT) begin
			seqIf.start = 1'b0;
		end
		if (state == vrs_pkg::VRS_BOOT && enablePrev == 1'b0) begin
			seqIf.start = 1'b1;
			seqIf.count = BOOT_CNT;
		end
		if (state == vrs_pkg::VRS_DELAY && enablePrev == 1'b0) begin
			seqIf.start = 1'b1;
			seqIf.count = PGDLY_CNT;
		end
	end

	// first cycle of a timed state
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			enablePrev <= 1'b0;
		end else begin
			enablePrev <= seqIf.run && !seqIf.done;
		end
	end

	// phase count sampled once after reset interval
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			twoPhase <= 1'b0;
		end else if (state == vrs_pkg::VRS_PHASE && powerOn) begin
			twoPhase <= phaseSelTwo;
		end
	end

	// VID capture with skew filter, only after clock-go
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			vidSeen <= OFF_CODE;
			vidPending <= 1'b0;
		end else if (state != vrs_pkg::VRS_DELAY && state != vrs_pkg::VRS_RUN) begin
			vidSeen <= voltage_id_bits;
			vidPending <= 1'b0;
		end else if (voltage_id_bits != vidSeen) begin
			vidSeen <= voltage_id_bits;
			vidPending <= 1'b1;
		end else if (skewIf.done) begin
			vidPending <= 1'b0;
		end
	end

	assign skewIf.run = vidPending || (voltage_id_bits != vidSeen);
	assign skewIf.start = voltage_id_bits != vidSeen;
	assign skewIf.count = SKEW_CNT;

	// target code: boot during soft-start, else filtered VID
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			targetCode <= OFF_CODE;
		end else if (!seqActive) begin
			targetCode <= OFF_CODE;
		end else if (state == vrs_pkg::VRS_PHASE) begin
			targetCode <= BOOT_CODE;
		end else if (vidPending && skewIf.done) begin
			targetCode <= vidSeen;
		end
	end

	// one code per step, higher code means lower voltage
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			dacCode <= OFF_CODE;
		end else if (!seqActive) begin
			dacCode <= OFF_CODE;
		end else if (stepIf.done && dacCode != targetCode) begin
			if (dacCode > targetCode) begin
				dacCode <= dacCode - VID_W'(1);
			end else begin
				dacCode <= dacCode + VID_W'(1);
			end
		end
	end

	assign stepping = seqActive && dacCode != targetCode;
	assign stepRun = seqActive && (stepping || state == vrs_pkg::VRS_SOFT);
	assign stepIf.run = stepRun;
	// reload the cycle after done; no loop from done back to start
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			stepArmed <= 1'b0;
		end else begin
			stepArmed <= stepRun && !stepIf.done;
		end
	end

	assign stepIf.start = stepRun && !stepArmed;
	// fast pace only when rising; load and done cycles take two
	assign stepIf.count = (fastUpSlew && dacCode > targetCode) ? FAST_CNT - TW'(2)
		: SLOW_CNT - TW'(2);

	// masking after VID and sleep changes
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sleepPrev <= 1'b0;
			maskRun <= 1'b0;
		end else begin
			sleepPrev <= deeperSleep;
			if (!seqActive) begin
				maskRun <= 1'b0;
			end else if (maskIf.start) begin
				maskRun <= 1'b1;
			end else if (maskIf.done) begin
				maskRun <= 1'b0;
			end
		end
	end

	assign maskIf.run = maskRun || maskIf.start;
	// each VID change in run state, except one away from OFF_CODE, reloads from full
	assign maskIf.start = seqActive && ((voltage_id_bits != vidSeen && vidSeen != OFF_CODE
		&& state == vrs_pkg::VRS_RUN) || deeperSleep != sleepPrev);
	// deep droop in sleep entry or slow exit stretches the mask
	assign maskIf.count = (droopOver200mV && (deeperSleep || slowSleepExit))
		? MASKX_CNT : MASK_CNT;

	// hold mask 100 us after the last step lands
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			finalRun <= 1'b0;
		end else if (!seqActive) begin
			finalRun <= 1'b0;
		end else if (finalIf.start) begin
			finalRun <= 1'b1;
		end else if (finalIf.done) begin
			finalRun <= 1'b0;
		end
	end

	assign finalIf.run = finalRun || finalIf.start;
	assign finalIf.start = state == vrs_pkg::VRS_RUN && stepIf.done
		&& (dacCode == targetCode + VID_W'(1) || targetCode == dacCode + VID_W'(1));
	assign finalIf.count = FINAL_CNT;

	// current limit persistence
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ilimRun <= 1'b0;
		end else begin
			ilimRun <= seqActive && currentOver;
		end
	end

	assign ilimIf.run = seqActive && currentOver;
	assign ilimIf.start = currentOver && !ilimRun;
	assign ilimIf.count = LIMIT_SET_PIN_CNT;

	// window with low limit dropped for small targets
	assign goodRaw = !outAboveHigh && (outAboveLow || dacCode > LOW_CODE);

	// outputs
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cpu_clock_go_n <= 1'b1;
			power_good_out_oe_n <= 1'b0;
			senseRefPullDown <= 1'b1;
			softStartDone <= 1'b0;
			forcePwm <= 1'b0;
			rampClamp <= 1'b0;
			switching <= 1'b0;
			latchedOff <= 1'b0;
		end else begin
			cpu_clock_go_n <= !(state == vrs_pkg::VRS_DELAY || state == vrs_pkg::VRS_RUN);
			// pulled low unless sequence done and window good or masked (mask, final hold, stepping, VID pending)
			power_good_out_oe_n <= state == vrs_pkg::VRS_RUN
				&& (goodRaw || maskIf.run || finalIf.run || stepping || vidPending);
			senseRefPullDown <= !powerOn;
			softStartDone <= state == vrs_pkg::VRS_BOOT || state == vrs_pkg::VRS_DELAY
				|| state == vrs_pkg::VRS_RUN;
			forcePwm <= stepping || vidPending;
			rampClamp <= seqActive && outBelow200mV && state != vrs_pkg::VRS_RUN;
			switching <= seqActive && state != vrs_pkg::VRS_RESET && state != vrs_pkg::VRS_PHASE;
			latchedOff <= state == vrs_pkg::VRS_LATCH;
		end
	end

	assign power_good_out_o = 1'b0;
endmodule

/* vrs_defs.svh */
// Purpose: timing counts and widths for the startup and VID supervisor
// Assumes: 20 MHz clock, 50 ns period
// Notes:   times in their own units; cycle counts derived below
`ifndef VRS_DEFS_SVH
`define VRS_DEFS_SVH

`define VRS_CLK_MHZ        20
`define VRS_RESET_US       55
`define VRS_RESET_CYC      (`VRS_RESET_US * `VRS_CLK_MHZ)
`define VRS_BOOT_US        100
`define VRS_BOOT_CYC       (`VRS_BOOT_US * `VRS_CLK_MHZ)
`define VRS_PGDLY_MS       9
`define VRS_PGDLY_CYC      (`VRS_PGDLY_MS * 1000 * `VRS_CLK_MHZ)
`define VRS_LIMIT_SET_PIN_MS        9
`define VRS_LIMIT_SET_PIN_CYC       (`VRS_LIMIT_SET_PIN_MS * 1000 * `VRS_CLK_MHZ)
`define VRS_MASK_US        130
`define VRS_MASK_CYC       (`VRS_MASK_US * `VRS_CLK_MHZ)
`define VRS_MASK_EXT_US    260
`define VRS_MASK_EXT_CYC   (`VRS_MASK_EXT_US * `VRS_CLK_MHZ)
`define VRS_FINAL_US       100
`define VRS_FINAL_CYC      (`VRS_FINAL_US * `VRS_CLK_MHZ)
`define VRS_SKEW_NS        400
`define VRS_SKEW_CYC       ((`VRS_SKEW_NS * `VRS_CLK_MHZ + 999) / 1000)
// one 12.5 mV step: 4 us at slow rate, 1 us at fast rate
`define VRS_STEP_SLOW_US   4
`define VRS_STEP_SLOW_CYC  (`VRS_STEP_SLOW_US * `VRS_CLK_MHZ)
`define VRS_STEP_FAST_US   1
`define VRS_STEP_FAST_CYC  (`VRS_STEP_FAST_US * `VRS_CLK_MHZ)
`define VRS_VID_W          7
`define VRS_BOOT_CODE      7'h3E
`define VRS_LOW_DAC_CODE   7'h60

`endif

/* vrs_pkg.sv */
// Purpose: types for the startup and VID supervisor
// Assumes: nothing
// Notes:   constants live in vrs_defs.svh
package vrs_pkg;
	typedef enum logic [2:0] {
		VRS_OFF,
		VRS_RESET,
		VRS_PHASE,
		VRS_SOFT,
		VRS_BOOT,
		VRS_DELAY,
		VRS_RUN,
		VRS_LATCH
	} vrs_state_e;
endpackage

/* vrs_timer_if.sv */
// Purpose: carries load and done of one down counter
// Assumes: single clock
// Notes:   start loads count, done is a level
`timescale 1ns/10ps
interface vrs_timer_if #(parameter int W = 24);
	logic         start;
	logic [W-1:0] count;
	logic         run;
	logic         done;
	modport owner (output start, output count, output run, input done);
	modport timer (input start, input count, input run, output done);
endinterface

/* vrs_timer.sv */
// Purpose: loadable down counter with done flag
// Assumes: synchronous active low reset
// Notes:   done high when count reaches zero while run
`timescale 1ns/10ps
module vrs_timer #(
	parameter int W = 24
) (
	input  wire logic   clock,
	input  wire logic   rst_n,
	vrs_timer_if.timer  tif
);
	logic [W-1:0] remain;

	always_ff @(posedge clock) begin
		if (!rst_n || !tif.run) begin
			remain <= '0;
		end else if (tif.start) begin
			remain <= tif.count;
		end else if (remain != '0) begin
			remain <= remain - W'(1);
		end
	end

	assign tif.done = tif.run && !tif.start && (remain == '0);
endmodule

/* vrs_supervisor_monitor.sv */
// Purpose: assertions on the startup and VID supervisor ports
// Assumes: one clock, synchronous active low reset
// Notes:   bound from tb_top
`timescale 1ns/10ps
`include "vrs_defs.svh"
module vrs_supervisor_monitor #(
	parameter int VID_W     = 7,
	parameter int PGDLY_CYC = 200,
	parameter int LIMIT_SET_PIN_CYC  = 200
) (
	input wire logic             clock,
	input wire logic             rst_n,
	input wire logic             enable,
	input wire logic             supplyOk,
	input wire logic [VID_W-1:0] voltage_id_bits,
	input wire logic             currentOver,
	input wire logic [VID_W-1:0] dacCode,
	input wire logic             cpu_clock_go_n,
	input wire logic             power_good_out_o,
	input wire logic             power_good_out_oe_n,
	input wire logic             senseRefPullDown,
	input wire logic             softStartDone,
	input wire logic             forcePwm,
	input wire logic             switching,
	input wire logic             latchedOff
);
	localparam int FAST_GAP = `VRS_STEP_FAST_CYC - 1;
	int   goLow;
	int   overRun;
	int   quiet;
	logic steady;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// low time of clock-go, run of current limit, cycles since a dac step
	always_ff @(posedge clock) begin
		goLow   <= (!rst_n || cpu_clock_go_n) ? 0 : goLow + 1;
		overRun <= (!rst_n || !currentOver) ? 0 : overRun + 1;
		quiet   <= (!rst_n || $changed(dacCode)) ? 0 : quiet + 1;
		steady  <= rst_n && enable && supplyOk && !latchedOff;
	end
	a_pg_delay: assert property ($rose(power_good_out_oe_n) |-> goLow >= PGDLY_CYC - 2)
		else $error("power good released before clock-go delay");
	a_pg_gate: assert property ($rose(power_good_out_oe_n) |-> softStartDone && !cpu_clock_go_n && !latchedOff)
		else $error("power good released outside run");
	a_od_low: assert property (power_good_out_o == 1'h0)
		else $error("power good data not low");
	a_off_pull: assert property ((!enable || !supplyOk) [*3] |-> senseRefPullDown)
		else $error("sense pull-down off in shutdown");
	a_off_clear: assert property ((!enable || !supplyOk) [*3] |-> cpu_clock_go_n && !softStartDone && !latchedOff && !power_good_out_oe_n)
		else $error("sequence state kept in shutdown");
	a_dac_step: assert property ($changed(dacCode) && steady && enable && supplyOk && !latchedOff
		|-> dacCode == $past(dacCode) + 7'h01 || dacCode == $past(dacCode) - 7'h01)
		else $error("dac code skipped a level");
	a_step_gap: assert property ($changed(dacCode) && steady && enable && supplyOk && !latchedOff |-> quiet >= FAST_GAP)
		else $error("dac steps too close");
	a_skew_hold: assert property ($changed(voltage_id_bits) && !cpu_clock_go_n && !forcePwm |=> $stable(dacCode) [*7])
		else $error("new code used inside skew time");
	a_boot_hold: assert property (softStartDone && cpu_clock_go_n && steady && enable && supplyOk |-> dacCode == `VRS_BOOT_CODE)
		else $error("dac left boot code before clock-go");
	a_latch_time: assert property ($rose(latchedOff) |-> overRun >= LIMIT_SET_PIN_CYC - 2)
		else $error("latch-off before limit time");
	a_latch_quiet: assert property (latchedOff && $past(latchedOff) |-> !switching && !power_good_out_oe_n)
		else $error("switching or good while latched off");
	a_pwm_step: assert property ($changed(dacCode) && steady && enable && supplyOk && !cpu_clock_go_n |-> $past(forcePwm))
		else $error("dac stepped without forced pwm");
	c_pg_up: cover property ($rose(power_good_out_oe_n));
	c_latch: cover property ($rose(latchedOff));
	c_step: cover property ($changed(dacCode) && !cpu_clock_go_n);
endmodule

/* vrs_host_model.sv */
// Purpose: host processor model driving the voltage-ID lines
// Assumes: drives on the falling edge
// Notes:   lines toggle every cycle until clock-go is low
`timescale 1ns/10ps
module vrs_host_model (
	input  wire logic        clock,
	input  wire logic        cpu_clock_go_n,
	input  wire logic [6:0]  target,
	input  wire logic [15:0] gap,
	output logic      [6:0]  vid
);
	logic        live = 1'h0;
	logic [15:0] hold = 16'h0000;
	initial vid = 7'h00;
	always @(negedge clock) begin
		if (cpu_clock_go_n) begin
			vid  <= ~vid;
			live <= 1'h0;
		end else if (!live) begin
			vid  <= target;
			live <= 1'h1;
			hold <= gap;
		end else if (hold != 16'h0000) begin
			hold <= hold - 16'h0001;
		end else if (vid != target) begin
			vid  <= (vid < target) ? vid + 7'h01 : vid - 7'h01;
			hold <= gap;
		end
	end
endmodule

/* tb_top.sv */
// Purpose: self-checking bench for the startup and VID supervisor
// Assumes: 20 MHz clock, shortened power-good and limit counts
// Notes:   inputs change on the falling edge
`timescale 1ns/10ps
module tb_top;
	localparam int PG    = 200;
	localparam int IL    = 200;
	localparam int GO_LO = 1000 + 65 * 80 + 2000;
	localparam int GO_HI = 1200 + 65 * 80 + 2000 + 10;
	logic        clock = 1'h0, rst_n = 1'h0, enable = 1'h0, supplyOk = 1'h1;
	logic        phaseSelTwo = 1'h1, deeperSleep = 1'h0, droopOver200mV = 1'h0;
	logic        outAboveLow = 1'h1, outAboveHigh = 1'h0, outBelow200mV = 1'h1;
	logic        currentOver = 1'h0, fastUpSlew = 1'h0, slowSleepExit = 1'h0;
	logic [6:0]  target = 7'h3E;
	logic [15:0] gap = 16'h001E;
	logic [6:0]  voltage_id_bits, dacCode;
	logic        cpu_clock_go_n, power_good_out_o, power_good_out_oe_n, senseRefPullDown;
	logic        softStartDone, twoPhase, forcePwm, rampClamp, switching, latchedOff;
	logic        pgWire;
	int          failures = 0, totalChecks = 0, cycles = 0;
	assign pgWire = power_good_out_oe_n ? 1'h1 : power_good_out_o;
	always #25 clock = ~clock;
	vr_startup_vid_supervisor #(.PGDLY_CYC(PG), .LIMIT_SET_PIN_CYC(IL)) i_dut (
		.clock(clock), .rst_n(rst_n), .enable(enable), .supplyOk(supplyOk),
		.phaseSelTwo(phaseSelTwo), .voltage_id_bits(voltage_id_bits),
		.deeperSleep(deeperSleep), .slowSleepExit(slowSleepExit),
		.droopOver200mV(droopOver200mV),
		.outAboveLow(outAboveLow), .outAboveHigh(outAboveHigh),
		.outBelow200mV(outBelow200mV), .currentOver(currentOver), .fastUpSlew(fastUpSlew),
		.dacCode(dacCode), .cpu_clock_go_n(cpu_clock_go_n),
		.power_good_out_o(power_good_out_o), .power_good_out_oe_n(power_good_out_oe_n),
		.senseRefPullDown(senseRefPullDown), .softStartDone(softStartDone),
		.twoPhase(twoPhase), .forcePwm(forcePwm), .rampClamp(rampClamp),
		.switching(switching), .latchedOff(latchedOff));
	vrs_host_model i_host (.clock(clock), .cpu_clock_go_n(cpu_clock_go_n), .target(target),
		.gap(gap), .vid(voltage_id_bits));
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		totalChecks++;
		if (seen !== want) begin
			failures++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic close_out();
		$display("checks %0d failures %0d", totalChecks, failures);
		if (failures == 0 && totalChecks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic t_startup();
		int n;
		enable = 1'h1;
		for (n = 0; n < GO_HI + 100 && cpu_clock_go_n !== 1'h0; n++) begin
			@(negedge clock);
			if (n == 3000) begin
				check(rampClamp, 1'h1);
				check(pgWire, 1'h0);
				outBelow200mV = 1'h0;
			end
		end
		check(n >= GO_LO && n <= GO_HI, 1'h1);
		check(dacCode, 7'h3E);
		check(twoPhase, phaseSelTwo);
		check(senseRefPullDown, 1'h0);
		for (n = 0; n < PG + 50 && power_good_out_oe_n !== 1'h1; n++) @(negedge clock);
		check(n >= PG - 2 && n <= PG + 3, 1'h1);
		check(pgWire, 1'h1);
		$display("test startup done");
	endtask
	task automatic t_mask();
		int n;
		target = 7'h3D;
		for (n = 0; n < 100 && voltage_id_bits !== 7'h3D; n++) @(negedge clock);
		outAboveLow = 1'h0;
		tick(2000);
		check(pgWire, 1'h1);
		check(dacCode, 7'h3D);
		target = 7'h3C;
		tick(1500);
		check(pgWire, 1'h1);
		tick(5000);
		check(pgWire, 1'h0);
		outAboveLow = 1'h1;
		tick(10);
		check(pgWire, 1'h1);
		outAboveHigh = 1'h1;
		tick(10);
		check(pgWire, 1'h0);
		outAboveHigh = 1'h0;
		tick(10);
		$display("test mask done");
	endtask
	task automatic t_slew(input logic fast, input logic [6:0] to, input int lo, input int hi);
		int n;
		fastUpSlew = fast;
		gap = 16'h0000;
		target = to;
		for (n = 0; n < 100 && voltage_id_bits !== to; n++) @(negedge clock);
		for (n = 0; n < 1000 && dacCode !== to; n++) @(negedge clock);
		check(n >= lo && n <= hi, 1'h1);
		$display("test slew done");
	endtask
	task automatic t_sleep();
		outAboveLow = 1'h0;
		droopOver200mV = 1'h1;
		deeperSleep = 1'h1;
		tick(4000);
		check(pgWire, 1'h1);
		tick(2000);
		check(pgWire, 1'h0);
		slowSleepExit = 1'h1;
		deeperSleep = 1'h0;
		tick(4000);
		check(pgWire, 1'h1);
		tick(2000);
		check(pgWire, 1'h0);
		droopOver200mV = 1'h0;
		slowSleepExit = 1'h0;
		deeperSleep = 1'h1;
		tick(2000);
		check(pgWire, 1'h1);
		tick(1000);
		check(pgWire, 1'h0);
		outAboveLow = 1'h1;
		deeperSleep = 1'h0;
		tick(10);
		check(pgWire, 1'h1);
		$display("test sleep done");
	endtask
	task automatic t_lowdac();
		int n;
		target = 7'h62;
		for (n = 0; n < 4000 && dacCode !== 7'h62; n++) @(negedge clock);
		check(dacCode, 7'h62);
		outAboveLow = 1'h0;
		tick(3000);
		check(pgWire, 1'h1);
		outAboveLow = 1'h1;
		$display("test low dac done");
	endtask
	task automatic t_latch();
		int n;
		currentOver = 1'h1;
		tick(IL / 2);
		currentOver = 1'h0;
		tick(2);
		check(latchedOff, 1'h0);
		check(switching, 1'h1);
		currentOver = 1'h1;
		for (n = 0; n < IL + 20 && latchedOff !== 1'h1; n++) @(negedge clock);
		check(n >= IL - 3 && n <= IL + 3, 1'h1);
		tick(2);
		check(switching, 1'h0);
		check(pgWire, 1'h0);
		currentOver = 1'h0;
		target = 7'h3E;
		outBelow200mV = 1'h1;
		phaseSelTwo = 1'h0;
		enable = 1'h0;
		tick(3);
		check(latchedOff, 1'h0);
		check(senseRefPullDown, 1'h1);
		check(cpu_clock_go_n, 1'h1);
		$display("test latch done");
		t_startup();
		supplyOk = 1'h0;
		tick(3);
		check(senseRefPullDown, 1'h1);
		check(pgWire, 1'h0);
		supplyOk = 1'h1;
		$display("test supply loss done");
	endtask
	initial begin
		tick(4);
		rst_n = 1'h1;
		t_startup();
		t_mask();
		t_slew(1'h1, 7'h38, 3 * 20, 8 + 4 * 20 + 10);
		t_slew(1'h0, 7'h3C, 3 * 80, 8 + 4 * 80 + 10);
		t_sleep();
		t_lowdac();
		t_latch();
		close_out();
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles > 70000) begin
			failures++;
			$display("unexpected at %0t: run too long", $time);
			close_out();
		end
	end
endmodule
bind vr_startup_vid_supervisor vrs_supervisor_monitor #(.VID_W(VID_W),
	.PGDLY_CYC(PGDLY_CYC), .LIMIT_SET_PIN_CYC(LIMIT_SET_PIN_CYC)) i_mon (
	.clock(clock), .rst_n(rst_n), .enable(enable), .supplyOk(supplyOk),
	.voltage_id_bits(voltage_id_bits), .currentOver(currentOver), .dacCode(dacCode),
	.cpu_clock_go_n(cpu_clock_go_n), .power_good_out_o(power_good_out_o),
	.power_good_out_oe_n(power_good_out_oe_n), .senseRefPullDown(senseRefPullDown),
	.softStartDone(softStartDone), .forcePwm(forcePwm), .switching(switching),
	.latchedOff(latchedOff));
